// ### timer_pkg.sv
// Constants, types and register map of the capture/compare timer
package timer_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
  localparam logic [3:0] OFS_CTRL_ONE = 4'h2;
  localparam logic [3:0] OFS_FLAGS = 4'h3;
  localparam logic [3:0] OFS_CAP1_HI = 4'h4;
  localparam logic [3:0] OFS_CAP1_LO = 4'h5;
  localparam logic [3:0] OFS_CMP1_HI = 4'h6;
  localparam logic [3:0] OFS_CMP1_LO = 4'h7;
  localparam logic [3:0] OFS_CNT_HI = 4'h8;
  localparam logic [3:0] OFS_CNT_LO = 4'h9;
  localparam logic [3:0] OFS_ALT_HI = 4'hA;
  localparam logic [3:0] OFS_ALT_LO = 4'hB;
  localparam logic [3:0] OFS_CAP2_HI = 4'hC;
  localparam logic [3:0] OFS_CAP2_LO = 4'hD;
  localparam logic [3:0] OFS_CMP2_HI = 4'hE;
  localparam logic [3:0] OFS_CMP2_LO = 4'hF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CAP_IRQ_EN = 7;
  localparam int CMP_IRQ_EN = 6;
  localparam int OVF_IRQ_EN = 5;
  localparam int FORCE_TWO = 4;
  localparam int FORCE_ONE = 3;
  localparam int LEVEL_TWO = 2;
  localparam int CAP1_EDGE = 1;
  localparam int LEVEL_ONE = 0;
  localparam int PIN1_EN = 7;
  localparam int PIN2_EN = 6;
  localparam int PULSE_BIT = 5;
  localparam int PWM_BIT = 4;
  localparam int CLK_SEL_HI = 3;
  localparam int CLK_SEL_LO = 2;
  localparam int CAP2_EDGE = 1;
  localparam int EXT_EDGE = 0;
  localparam int CAP1_FLAG = 7;
  localparam int CMP1_FLAG = 6;
  localparam int OVF_FLAG = 5;
  localparam int CAP2_FLAG = 4;
  localparam int CMP2_FLAG = 3;
  localparam int FREEZE_BIT = 2;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAG_MASK = 8'hFC;
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  typedef enum logic [1:0] {
    CLK_DIV4 = 2'h0,
    CLK_DIV2 = 2'h1,
    CLK_DIV8 = 2'h2,
    CLK_EXT = 2'h3
  } clk_sel_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic compareOne;
    logic compareTwo;
    logic ownedOne;
    logic ownedTwo;
  } pin_out_s;

endpackage

// ### capture_compare_timer.sv
// Control, status and counting logic of the capture/compare timer
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module capture_compare_timer
  import timer_pkg::*;
#(
  parameter bit EXT_CLK_PRESENT = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire reg_req_s busReq,
  output logic [7:0] rdData,
  input wire logic cpuIrqMask,
  input wire logic captureInputOne,
  input wire logic captureInputTwo,
  input wire logic externalCountClock,
  output pin_out_s pins,
  output logic timerIrq
);

  typedef struct packed {
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [7:0] flags;
    logic [7:0] armed;
    logic [15:0] capOne;
    logic [15:0] capTwo;
    logic [15:0] cmpOne;
    logic [15:0] cmpTwo;
    logic [15:0] count;
    logic [2:0] presc;
    logic capOnePrev;
    logic capTwoPrev;
    logic extPrev;
    pin_out_s pinOut;
    logic irq;
    logic [7:0] rdData;
  } state_s;

  localparam state_s STATE_RESET = '{
    ctrlOne: CTRL_RESET,
    ctrlTwo: CTRL_RESET,
    flags: FLAGS_RESET,
    armed: FLAGS_RESET,
    capOne: CAP_RESET,
    capTwo: CAP_RESET,
    cmpOne: CMP_RESET,
    cmpTwo: CMP_RESET,
    count: COUNT_RESET,
    presc: 3'h0,
    capOnePrev: 1'b0,
    capTwoPrev: 1'b0,
    extPrev: 1'b0,
    pinOut: '0,
    irq: 1'b0,
    rdData: 8'h00
  };

  state_s st_ff;
  state_s nxt_st;

  logic pwmMode;
  logic pulseMode;
  logic freeze;
  logic tick;
  logic [2:0] prescLast;
  logic capOneEdge;
  logic capTwoEdge;
  logic extEdge;
  logic [15:0] cntInc;
  logic matchOne;
  logic matchTwo;
  logic overflow;
  logic access;
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  logic counterWrite;
  logic [7:0] csrImage;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    pwmMode = st_ff.ctrlTwo[PWM_BIT];
    pulseMode = st_ff.ctrlTwo[PULSE_BIT] && !pwmMode;
    freeze = st_ff.flags[FREEZE_BIT];
    access = busReq.wr || busReq.rd;
    flagSet = 8'h00;
    flagClr = 8'h00;
    csrImage = st_ff.flags & FLAG_MASK;

    nxt_st.capOnePrev = captureInputOne;
    nxt_st.capTwoPrev = captureInputTwo;
    nxt_st.extPrev = externalCountClock;

    capOneEdge = st_ff.ctrlOne[CAP1_EDGE] ? (captureInputOne && !st_ff.capOnePrev)
                                           : (!captureInputOne && st_ff.capOnePrev);
    capTwoEdge = st_ff.ctrlTwo[CAP2_EDGE] ? (captureInputTwo && !st_ff.capTwoPrev)
                                           : (!captureInputTwo && st_ff.capTwoPrev);
    extEdge = st_ff.ctrlTwo[EXT_EDGE] ? (externalCountClock && !st_ff.extPrev)
                                       : (!externalCountClock && st_ff.extPrev);

    unique case (clk_sel_e'(st_ff.ctrlTwo[CLK_SEL_HI:CLK_SEL_LO]))
      CLK_DIV4: prescLast = DIV4_LAST;
      CLK_DIV2: prescLast = DIV2_LAST;
      CLK_DIV8: prescLast = DIV8_LAST;
      CLK_EXT: prescLast = DIV8_LAST;
    endcase

    tick = 1'b0;
    if (!freeze) begin
      if (clk_sel_e'(st_ff.ctrlTwo[CLK_SEL_HI:CLK_SEL_LO]) == CLK_EXT) begin
        tick = EXT_CLK_PRESENT && extEdge;
      end else begin
        tick = (st_ff.presc >= prescLast);
        nxt_st.presc = tick ? 3'h0 : st_ff.presc + 3'h1;
      end
    end

    cntInc = st_ff.count + 16'h0001;
    matchOne = tick && (cntInc == st_ff.cmpOne);
    matchTwo = tick && (cntInc == st_ff.cmpTwo);
    overflow = tick && (st_ff.count == COUNT_MAX);
    if (tick) begin
      nxt_st.count = cntInc;
    end

    flagSet[OVF_FLAG] = overflow;

    if (capTwoEdge) begin
      nxt_st.capTwo = st_ff.count;
      flagSet[CAP2_FLAG] = 1'b1;
    end

    if (pwmMode) begin
      if (matchOne) begin
        nxt_st.pinOut.compareOne = st_ff.ctrlOne[LEVEL_ONE];
      end
      if (matchTwo) begin
        nxt_st.pinOut.compareOne = st_ff.ctrlOne[LEVEL_TWO];
        nxt_st.count = COUNT_RESET;
        flagSet[CAP1_FLAG] = 1'b1;
      end
    end else if (pulseMode) begin
      // pulse starts at edge
      // A frozen counter must not be reloaded by a capture edge either
      if (capOneEdge && !freeze) begin
        nxt_st.count = COUNT_RESET;
        nxt_st.pinOut.compareOne = st_ff.ctrlOne[LEVEL_TWO];
      end else if (matchOne) begin
        nxt_st.pinOut.compareOne = st_ff.ctrlOne[LEVEL_ONE];
      end
      flagSet[CMP2_FLAG] = matchTwo;
    end else begin
      if (capOneEdge) begin
        nxt_st.capOne = st_ff.count;
        flagSet[CAP1_FLAG] = 1'b1;
      end
      flagSet[CMP1_FLAG] = matchOne;
      flagSet[CMP2_FLAG] = matchTwo;
      if (matchOne && st_ff.ctrlTwo[PIN1_EN]) begin
        nxt_st.pinOut.compareOne = st_ff.ctrlOne[LEVEL_ONE];
      end
      if (matchTwo && st_ff.ctrlTwo[PIN2_EN]) begin
        nxt_st.pinOut.compareTwo = st_ff.ctrlOne[LEVEL_TWO];
      end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    counterWrite = 1'b0;
    if (busReq.wr) begin
      unique case (busReq.addr)
        OFS_CTRL_ONE: begin
          nxt_st.ctrlOne = busReq.wdata;
          if (busReq.wdata[FORCE_ONE] && st_ff.ctrlTwo[PIN1_EN]) begin
            nxt_st.pinOut.compareOne = busReq.wdata[LEVEL_ONE];
          end
          if (busReq.wdata[FORCE_TWO] && st_ff.ctrlTwo[PIN2_EN]) begin
            nxt_st.pinOut.compareTwo = busReq.wdata[LEVEL_TWO];
          end
        end
        OFS_CTRL_TWO: nxt_st.ctrlTwo = busReq.wdata;
        OFS_CMP1_HI: nxt_st.cmpOne[15:8] = busReq.wdata;
        OFS_CMP1_LO: nxt_st.cmpOne[7:0] = busReq.wdata;
        OFS_CMP2_HI: nxt_st.cmpTwo[15:8] = busReq.wdata;
        OFS_CMP2_LO: nxt_st.cmpTwo[7:0] = busReq.wdata;
        OFS_CNT_LO, OFS_ALT_LO: counterWrite = 1'b1;
        default: ;
      endcase
    end
    if (counterWrite) begin
      nxt_st.count = COUNT_RESET;
      nxt_st.presc = 3'h0;
    end

    // ****************************************************************
    // Flag read-sequence clearing
    // ****************************************************************
    // Only flags seen by the status read are cleared, so a later event survives
    if (access) begin
      unique case (busReq.addr)
        OFS_CAP1_LO: flagClr[CAP1_FLAG] = st_ff.armed[CAP1_FLAG];
        OFS_CMP1_LO: flagClr[CMP1_FLAG] = st_ff.armed[CMP1_FLAG];
        OFS_CNT_LO: flagClr[OVF_FLAG] = st_ff.armed[OVF_FLAG];
        OFS_CAP2_LO: flagClr[CAP2_FLAG] = st_ff.armed[CAP2_FLAG];
        OFS_CMP2_LO: flagClr[CMP2_FLAG] = st_ff.armed[CMP2_FLAG];
        default: ;
      endcase
    end
    nxt_st.armed = st_ff.armed & ~flagClr;
    if (busReq.rd && busReq.addr == OFS_FLAGS) begin
      nxt_st.armed = st_ff.flags & FLAG_MASK & ~flagSet;
    end
    // Set beats clear in the same cycle
    nxt_st.flags = (st_ff.flags & ~flagClr) | flagSet;
    if (busReq.wr && busReq.addr == OFS_FLAGS) begin
      nxt_st.flags[FREEZE_BIT] = busReq.wdata[FREEZE_BIT];
    end

    // ****************************************************************
    // Pin hand-over and interrupt
    // ****************************************************************
    // pin enables and the freeze bit gate pin ownership
    nxt_st.pinOut.ownedOne = nxt_st.ctrlTwo[PIN1_EN] && !nxt_st.flags[FREEZE_BIT];
    nxt_st.pinOut.ownedTwo = nxt_st.ctrlTwo[PIN2_EN] && !nxt_st.flags[FREEZE_BIT];

    nxt_st.irq = !cpuIrqMask && (
      (st_ff.ctrlOne[CAP_IRQ_EN] && (st_ff.flags[CAP1_FLAG] || st_ff.flags[CAP2_FLAG])) ||
      (st_ff.ctrlOne[CMP_IRQ_EN] && (st_ff.flags[CMP1_FLAG] || st_ff.flags[CMP2_FLAG])) ||
      (st_ff.ctrlOne[OVF_IRQ_EN] && st_ff.flags[OVF_FLAG]));

    // ****************************************************************
    // Read data
    // ****************************************************************
    nxt_st.rdData = 8'h00;
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFS_CTRL_ONE: nxt_st.rdData = st_ff.ctrlOne;
        OFS_CTRL_TWO: nxt_st.rdData = st_ff.ctrlTwo;
        OFS_FLAGS: nxt_st.rdData = csrImage;
        OFS_CAP1_HI: nxt_st.rdData = st_ff.capOne[15:8];
        OFS_CAP1_LO: nxt_st.rdData = st_ff.capOne[7:0];
        OFS_CMP1_HI: nxt_st.rdData = st_ff.cmpOne[15:8];
        OFS_CMP1_LO: nxt_st.rdData = st_ff.cmpOne[7:0];
        OFS_CNT_HI, OFS_ALT_HI: nxt_st.rdData = st_ff.count[15:8];
        OFS_CNT_LO, OFS_ALT_LO: nxt_st.rdData = st_ff.count[7:0];
        OFS_CAP2_HI: nxt_st.rdData = st_ff.capTwo[15:8];
        OFS_CAP2_LO: nxt_st.rdData = st_ff.capTwo[7:0];
        OFS_CMP2_HI: nxt_st.rdData = st_ff.cmpTwo[15:8];
        OFS_CMP2_LO: nxt_st.rdData = st_ff.cmpTwo[7:0];
        default: nxt_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdData = st_ff.rdData;
  assign pins = st_ff.pinOut;
  assign timerIrq = st_ff.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_irq_cpu_mask: assert property (cpuIrqMask |=> !timerIrq)
    else $error("interrupt raised while cpu mask set");
  a_irq_capture_src: assert property (
    (!cpuIrqMask && st_ff.ctrlOne[CAP_IRQ_EN] && st_ff.flags[CAP2_FLAG]) |=> timerIrq)
    else $error("capture flag did not raise interrupt");
  a_irq_compare_src: assert property (
    (!cpuIrqMask && st_ff.ctrlOne[CMP_IRQ_EN] && st_ff.flags[CMP1_FLAG]) |=> timerIrq)
    else $error("compare flag did not raise interrupt");
  a_irq_overflow_off: assert property (
    (st_ff.ctrlOne[7:5] == 3'h1 && !st_ff.flags[OVF_FLAG]) |=> !timerIrq)
    else $error("interrupt without an enabled flag");
  a_force_level_two: assert property (
    (busReq.wr && busReq.addr == OFS_CTRL_ONE && busReq.wdata[FORCE_TWO]
     && st_ff.ctrlTwo[PIN2_EN]) |=> pins.compareTwo == $past(busReq.wdata[LEVEL_TWO]))
    else $error("forced level two not copied");
  a_freeze_count: assert property (
    (st_ff.flags[FREEZE_BIT] && !busReq.wr) |=> $stable(st_ff.count) && !pins.ownedOne)
    else $error("counter moved while frozen");
  a_overflow_flag: assert property (
    ($past(st_ff.count) == COUNT_MAX && st_ff.count == 16'h0000) |-> st_ff.flags[OVF_FLAG])
    else $error("rollover did not set overflow flag");
  a_count_restart: assert property (
    (busReq.wr && busReq.addr == OFS_ALT_LO) |=> st_ff.count == COUNT_RESET)
    else $error("counter write did not restart count");
  a_pwm_reload: assert property (
    (pwmMode && matchTwo && !busReq.wr) |=> st_ff.count == COUNT_RESET
      ##0 st_ff.flags[CAP1_FLAG])
    else $error("pwm period end missed reload");
  a_read_timing: assert property (
    (busReq.rd && busReq.addr == OFS_CTRL_TWO) |=> rdData == $past(st_ff.ctrlTwo)
      ##1 (rdData == 8'h00 || $past(busReq.rd)))
    else $error("read data misplaced");
  a_force_level_one: assert property (
    (busReq.wr && busReq.addr == OFS_CTRL_ONE && busReq.wdata[FORCE_ONE]
     && st_ff.ctrlTwo[PIN1_EN]) |=> pins.compareOne == $past(busReq.wdata[LEVEL_ONE]))
    else $error("forced level one not copied");
  a_pulse_start: assert property (
    (pulseMode && capOneEdge && !freeze && !busReq.wr) |=> st_ff.count == COUNT_RESET
      && pins.compareOne == $past(st_ff.ctrlOne[LEVEL_TWO]))
    else $error("capture edge did not start pulse");
  a_ext_clock_stop: assert property (
    (!EXT_CLK_PRESENT && clk_sel_e'(st_ff.ctrlTwo[CLK_SEL_HI:CLK_SEL_LO]) == CLK_EXT
     && !pulseMode && !busReq.wr) |=> $stable(st_ff.count))
    else $error("counter moved without an external clock pin");
  a_capture_two_flag: assert property (
    capTwoEdge |=> st_ff.flags[CAP2_FLAG] && st_ff.capTwo == $past(st_ff.count))
    else $error("capture two event not recorded");
  a_compare_one_flag: assert property (
    (!pwmMode && !pulseMode && matchOne) |=> st_ff.flags[CMP1_FLAG])
    else $error("compare one match did not set its flag");
  a_pwm_flags_quiet: assert property (
    (pwmMode && !st_ff.flags[CMP1_FLAG] && !st_ff.flags[CMP2_FLAG])
      |=> !st_ff.flags[CMP1_FLAG] && !st_ff.flags[CMP2_FLAG])
    else $error("compare flag set in pwm mode");
  a_capture_one_clear: assert property (
    (busReq.rd && busReq.addr == OFS_CAP1_LO && st_ff.armed[CAP1_FLAG]
     && !flagSet[CAP1_FLAG]) |=> !st_ff.flags[CAP1_FLAG])
    else $error("armed capture one flag not cleared");
  a_pin_two_release: assert property (
    (!st_ff.ctrlTwo[PIN2_EN] && !busReq.wr) |=> !pins.ownedTwo)
    else $error("pin two held while its enable is clear");

  c_pwm_period: cover property (pwmMode && matchTwo);
  c_pulse_start: cover property (pulseMode && capOneEdge);
  c_overflow_clear: cover property (st_ff.flags[OVF_FLAG] ##1 flagClr[OVF_FLAG]);
  c_capture_two: cover property (capTwoEdge ##1 st_ff.flags[CAP2_FLAG]);

endmodule // capture_compare_timer

`default_nettype wire

// ### timer_pins_model.sv
// Model of the capture inputs and external count clock feeding the timer
`timescale 1ns/10ps
`default_nettype none

module timer_pins_model (
  input wire logic mclk,
  output logic captureInputOne,
  output logic captureInputTwo,
  output logic externalCountClock
);
  initial begin
    captureInputOne = 1'b0;
    captureInputTwo = 1'b0;
    externalCountClock = 1'b0;
  end

  // Levels change just after an edge, as a synchronous source would
  task automatic setCapture(input int which, input logic level);
    @(posedge mclk);
    if (which == 1) begin
      captureInputOne <= level;
    end else begin
      captureInputTwo <= level;
    end
    repeat (3) @(posedge mclk);
  endtask

  // Count clock runs only when asked; idle low between bursts
  task automatic extTicks(input int n);
    repeat (n) begin
      @(posedge mclk);
      externalCountClock <= 1'b1;
      repeat (3) @(posedge mclk);
      externalCountClock <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule // timer_pins_model

`default_nettype wire

// ### capture_compare_timer_tb_top.sv
// Self-checking testbench of the capture/compare timer
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH at %0t got %h expected %h", $time, got, exp); end end

module capture_compare_timer_tb_top;
  import timer_pkg::*;

  logic mclk = 1'b0;
  logic reset = 1'b1;
  reg_req_s busReq = '0;
  logic [7:0] rdData;
  logic [7:0] rdDataNoExt;
  logic cpuIrqMask = 1'b0;
  logic capOne;
  logic capTwo;
  logic external_count_clock;
  pin_out_s pins;
  logic timerIrq;
  int errors = 0;
  int nTests = 0;
  logic [7:0] d;
  logic [7:0] c;
  logic [3:0] rstOfs [6] = '{OFS_CNT_HI, OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_FLAGS, OFS_CMP1_HI, 4'h0};
  logic [7:0] rstVal [6] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  int divs [3] = '{4, 2, 8};

  always #5 mclk = ~mclk;

  capture_compare_timer u_dut (
    .mclk(mclk),
    .reset(reset),
    .busReq(busReq),
    .rdData(rdData),
    .cpuIrqMask(cpuIrqMask),
    .captureInputOne(capOne),
    .captureInputTwo(capTwo),
    .externalCountClock(external_count_clock),
    .pins(pins),
    .timerIrq(timerIrq)
  );

  // Variant without the external count pin; only its read data is checked
  capture_compare_timer #(
    .EXT_CLK_PRESENT(1'b0)
  ) u_dut_noext (
    .mclk(mclk),
    .reset(reset),
    .busReq(busReq),
    .rdData(rdDataNoExt),
    .cpuIrqMask(cpuIrqMask),
    .captureInputOne(capOne),
    .captureInputTwo(capTwo),
    .externalCountClock(external_count_clock),
    .pins(),
    .timerIrq()
  );

  timer_pins_model u_pins (
    .mclk(mclk),
    .captureInputOne(capOne),
    .captureInputTwo(capTwo),
    .externalCountClock(external_count_clock)
  );

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wrReg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq <= '0;
  endtask

  task automatic rdReg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq <= '0;
    #1 v = rdData;
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic doReset();
    @(posedge mclk);
    reset <= 1'b1;
    waitClk(8);
    reset <= 1'b0;
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles
  initial begin
    #200000;
    errors++;
    finish_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    waitClk(8);
    reset <= 1'b0;
    // Reset values and the unmapped offset
    foreach (rstOfs[i]) begin
      rdReg(rstOfs[i], d);
      `CHK(d, rstVal[i])
    end
    wrReg(4'h0, 8'hFF);
    rdReg(4'h0, d);
    `CHK(d, 8'h00)

    // Overflow gated by its enable and the CPU mask
    doReset();
    wrReg(OFS_CTRL_TWO, 8'h04);
    waitClk(20);
    `CHK(timerIrq, 1'b0)
    wrReg(OFS_CTRL_ONE, 8'h20);
    waitClk(2);
    `CHK(timerIrq, 1'b1)
    cpuIrqMask <= 1'b1;
    waitClk(2);
    `CHK(timerIrq, 1'b0)
    cpuIrqMask <= 1'b0;
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h20)
    rdReg(OFS_ALT_LO, d);
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h20)
    rdReg(OFS_CNT_LO, d);
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h00)
    waitClk(2);
    `CHK(timerIrq, 1'b0)

    // Prescaler ratios: no overflow by 2 periods, overflow by 5
    foreach (divs[i]) begin
      doReset();
      wrReg(OFS_CTRL_TWO, 8'(i << 2));
      wrReg(OFS_CNT_LO, 8'h00);
      waitClk(2 * divs[i]);
      rdReg(OFS_FLAGS, d);
      `CHK(d & 8'h20, 8'h00)
      waitClk(3 * divs[i]);
      rdReg(OFS_FLAGS, d);
      `CHK(d & 8'h20, 8'h20)
    end

    // Compare one match, pin drive, flag clearing, force, freeze
    doReset();
    wrReg(OFS_CMP1_HI, 8'h00);
    wrReg(OFS_CMP1_LO, 8'h10);
    wrReg(OFS_CTRL_ONE, 8'h41);
    wrReg(OFS_CTRL_TWO, 8'h84);
    wrReg(OFS_CNT_LO, 8'h00);
    waitClk(60);
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h60)
    `CHK(pins.compareOne, 1'b1)
    `CHK(pins.ownedOne, 1'b1)
    `CHK(pins.ownedTwo, 1'b0)
    `CHK(timerIrq, 1'b1)
    rdReg(OFS_CMP1_LO, d);
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h20)
    wrReg(OFS_CTRL_TWO, 8'hC4);
    wrReg(OFS_CTRL_ONE, 8'h14);
    waitClk(1);
    `CHK(pins.compareTwo, 1'b1)
    wrReg(OFS_FLAGS, 8'hFF);
    rdReg(OFS_FLAGS, d);
    `CHK(d, 8'h24)
    `CHK(pins.ownedOne, 1'b0)
    rdReg(OFS_CNT_LO, c);
    waitClk(20);
    rdReg(OFS_CNT_LO, d);
    `CHK(d, c)
    wrReg(OFS_FLAGS, 8'h00);

    // Capture edges: wrong edge ignored, right edge flags
    doReset();
    wrReg(OFS_FLAGS, 8'h04);
    wrReg(OFS_CTRL_TWO, 8'h02);
    wrReg(OFS_CTRL_ONE, 8'h80);
    u_pins.setCapture(1, 1'b1);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'hD8, 8'h00)
    `CHK(timerIrq, 1'b0)
    u_pins.setCapture(1, 1'b0);
    u_pins.setCapture(2, 1'b1);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'hD8, 8'h90)
    `CHK(timerIrq, 1'b1)
    rdReg(OFS_CAP1_LO, d);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'hD8, 8'h10)
    rdReg(OFS_CAP2_LO, d);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'hD8, 8'h00)

    // External count clock, rising edges
    doReset();
    wrReg(OFS_CTRL_TWO, 8'h0D);
    wrReg(OFS_CNT_LO, 8'h00);
    u_pins.extTicks(3);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'h20, 8'h00)
    u_pins.extTicks(1);
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'h20, 8'h20)
    rdReg(OFS_CNT_LO, d);
    `CHK(d, 8'h00)
    `CHK(rdDataNoExt, 8'hFC)

    // PWM with single-pulse bit also set
    doReset();
    wrReg(OFS_CMP1_HI, 8'h00);
    wrReg(OFS_CMP1_LO, 8'h10);
    wrReg(OFS_CMP2_HI, 8'h00);
    wrReg(OFS_CMP2_LO, 8'h20);
    wrReg(OFS_CTRL_ONE, 8'h04);
    wrReg(OFS_CTRL_TWO, 8'hB4);
    wrReg(OFS_CNT_LO, 8'h00);
    waitClk(90);
    `CHK(pins.compareOne, 1'b1)
    waitClk(40);
    `CHK(pins.compareOne, 1'b0)
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'hC8, 8'h80)

    // Single pulse from a rising capture edge, then a forced level one
    doReset();
    wrReg(OFS_CMP1_HI, 8'h00);
    wrReg(OFS_CMP1_LO, 8'h10);
    wrReg(OFS_CMP2_HI, 8'h00);
    wrReg(OFS_CMP2_LO, 8'h20);
    wrReg(OFS_CTRL_ONE, 8'h06);
    wrReg(OFS_CTRL_TWO, 8'hA4);
    wrReg(OFS_ALT_LO, 8'h00);
    `CHK(pins.compareOne, 1'b0)
    u_pins.setCapture(1, 1'b1);
    `CHK(pins.compareOne, 1'b1)
    waitClk(80);
    `CHK(pins.compareOne, 1'b0)
    rdReg(OFS_FLAGS, d);
    `CHK(d & 8'h48, 8'h08)
    wrReg(OFS_CTRL_ONE, 8'h09);
    waitClk(1);
    `CHK(pins.compareOne, 1'b1)
    finish_test();
  end
endmodule // capture_compare_timer_tb_top

`default_nettype wire
